//--- verilog/gpo_defs.vh
// Purpose: Register indices, field positions and reset values of the GPIO block
// Assumes: Avalon-MM word addressing, register index equals word address
// Notes:   Byte address of a register is four times its index
`ifndef GPO_DEFS_VH
`define GPO_DEFS_VH

// ***************************************************************
// Register indices
// ***************************************************************
`define GPO_IDX_PORT_A_DATA   8'hd0
`define GPO_IDX_PORT_B_DATA   8'hd1
`define GPO_IDX_PORT_C_DATA   8'hd5
`define GPO_IDX_PORT_A_PULLUP 8'he0
`define GPO_IDX_PORT_B_PULLUP 8'he1
`define GPO_IDX_PORT_C_PULLUP 8'he5
`define GPO_IDX_OD_CTRL       8'he9
`define GPO_IDX_PORT_A_DIR    8'hb8
`define GPO_IDX_PORT_B_DIR    8'hc1
`define GPO_IDX_PORT_C_DIR    8'hc5
`define GPO_IDX_BIT_OP        8'hf0

// ***************************************************************
// Widths and implemented bits
// ***************************************************************
`define GPO_ADDR_W            8
`define GPO_BUS_W             32
`define GPO_REG_W             8
`define GPO_PORT_A_W          1
`define GPO_PORT_B_W          6
`define GPO_PORT_C_W          8
`define GPO_PORT_A_IMPL       8'h01
`define GPO_PORT_B_IMPL       8'h1f
`define GPO_PORT_C_IMPL       8'hff
`define GPO_INPUT_ONLY_BIT    5
`define GPO_INPUT_ONLY_MASK   8'h20
`define GPO_OD_SELECT_BIT     0
`define GPO_OD_PIN_BIT        0

// ***************************************************************
// Bit operation word fields
// ***************************************************************
`define GPO_BITOP_IDX_HI      7
`define GPO_BITOP_IDX_LO      0
`define GPO_BITOP_POS_HI      10
`define GPO_BITOP_POS_LO      8
`define GPO_BITOP_VAL         11

// ***************************************************************
// Reset values
// ***************************************************************
`define GPO_RST_REG           8'h00
`define GPO_RST_BUS           32'h0000_0000

`endif

//--- verilog/gpo_pin_drv.v
// Purpose: Drive logic of one port pin, push-pull or open-drain
// Assumes: Latch, direction and open-drain select come from registers
// Notes:   Pin never drives high while open-drain is active
`timescale 1ns/1ps
`default_nettype none

module gpo_pin_drv #(
  parameter OD_CAPABLE = 0
) (
  input  wire i_latch,
  input  wire i_dir,
  input  wire i_od_en,
  output wire o_out,
  output wire o_oe
);

  wire od_active;

  // Open-drain only acts with the pin in output direction
  assign od_active = (OD_CAPABLE != 0) && i_od_en && i_dir;

  // Open-drain: latch 1 floats, latch 0 sinks; direction left untouched
  assign o_out = od_active ? 1'b0 : i_latch;
  assign o_oe  = od_active ? ~i_latch : i_dir;

endmodule

`default_nettype wire

//--- verilog/gpo_port.v
// Purpose: Output latch, direction and pull-up registers of one port
// Assumes: Write strobes are one-cycle pulses from the bus slave
// Notes:   Bits outside the implemented mask stay zero
`timescale 1ns/1ps
`default_nettype none
`include "gpo_defs.vh"

module gpo_port #(
  parameter [7:0] IMPL = 8'hff
) (
  input  wire       i_clock,
  input  wire       i_reset,
  input  wire       i_data_we,
  input  wire       i_dir_we,
  input  wire       i_pu_we,
  input  wire [7:0] i_wdata,
  input  wire       i_bit_data_we,
  input  wire       i_bit_dir_we,
  input  wire [2:0] i_bit_pos,
  input  wire       i_bit_val,
  output wire [7:0] o_data,
  output wire [7:0] o_dir,
  output wire [7:0] o_pu
);

  reg [7:0] data_q;
  reg [7:0] dir_q;
  reg [7:0] pu_q;

  // Single bit change, others kept
  function [7:0] bit_merge;
    input [7:0] old;
    input [2:0] pos;
    input       val;
    reg   [7:0] sel;
    begin
      sel       = 8'h01 << pos;
      bit_merge = val ? (old | sel) : (old & ~sel);
    end
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      data_q <= `GPO_RST_REG;
      dir_q  <= `GPO_RST_REG;
      pu_q   <= `GPO_RST_REG;
    end
    else
    begin
      if (i_data_we)
        data_q <= i_wdata & IMPL;
      else if (i_bit_data_we)
        data_q <= bit_merge(data_q, i_bit_pos, i_bit_val) & IMPL;
      if (i_dir_we)
        dir_q <= i_wdata & IMPL;
      else if (i_bit_dir_we)
        dir_q <= bit_merge(dir_q, i_bit_pos, i_bit_val) & IMPL;
      if (i_pu_we)
        pu_q <= i_wdata & IMPL;
    end
  end

  assign o_data = data_q;
  assign o_dir  = dir_q;
  assign o_pu   = pu_q;

endmodule

`default_nettype wire

//--- verilog/gpo_top.v
// Purpose: GPIO block with three ports, pull-ups and one open-drain pin
// Assumes: Avalon-MM slave, word address is the register index
// Notes:   Every access takes two cycles; pull-up and open-drain regs are write-only
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpo_defs.vh"

module gpo_top (
  input  wire                     i_clock,
  input  wire                     i_reset,
  input  wire [`GPO_ADDR_W-1:0]   i_avs_address,
  input  wire                     i_avs_read,
  input  wire                     i_avs_write,
  input  wire [`GPO_BUS_W-1:0]    i_avs_writedata,
  input  wire [3:0]               i_avs_byteenable,
  output wire [`GPO_BUS_W-1:0]    o_avs_readdata,
  output wire                     o_avs_waitrequest,
  input  wire                     i_ext_reset_option,
  input  wire [`GPO_PORT_A_W-1:0] i_port_a_pin,
  output wire [`GPO_PORT_A_W-1:0] o_port_a_out,
  output wire [`GPO_PORT_A_W-1:0] o_port_a_oe,
  output wire [`GPO_PORT_A_W-1:0] o_port_a_pullup,
  input  wire [`GPO_PORT_B_W-1:0] i_port_b_pin,
  output wire [`GPO_PORT_B_W-1:0] o_port_b_out,
  output wire [`GPO_PORT_B_W-1:0] o_port_b_oe,
  output wire [`GPO_PORT_B_W-1:0] o_port_b_pullup,
  input  wire [`GPO_PORT_C_W-1:0] i_port_c_pin,
  output wire [`GPO_PORT_C_W-1:0] o_port_c_out,
  output wire [`GPO_PORT_C_W-1:0] o_port_c_oe,
  output wire [`GPO_PORT_C_W-1:0] o_port_c_pullup
);

  reg  [`GPO_BUS_W-1:0] rdata_q;
  reg  [`GPO_BUS_W-1:0] rdata_d;
  reg                   ack_q;
  reg                   od_q;
  wire                  req;
  wire                  wr_go;
  wire                  lane0;
  wire [7:0]            wbyte;
  wire [7:0]            bit_idx;
  wire [2:0]            bit_pos;
  wire                  bit_val;
  wire                  bit_go;
  wire [7:0]            a_data;
  wire [7:0]            a_dir;
  wire [7:0]            a_pu;
  wire [7:0]            b_data;
  wire [7:0]            b_dir;
  wire [7:0]            b_pu;
  wire [7:0]            c_data;
  wire [7:0]            c_dir;
  wire [7:0]            c_pu;
  wire [7:0]            b_dir_view;
  wire [7:0]            a_level;
  wire [7:0]            b_level;
  wire [7:0]            c_level;

  // Address match, used for every register strobe
  function hit;
    input [7:0] addr;
    input [7:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  // ***************************************************************
  // Avalon-MM slave handshake
  // ***************************************************************
  // One wait cycle gives a registered read path; writes land on the
  // edge where waitrequest is low, matching the master's sample edge.
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_go             = i_avs_write & ack_q;
  assign lane0             = i_avs_byteenable[0];
  assign wbyte             = i_avs_writedata[7:0];
  assign o_avs_readdata    = rdata_q;

  always @(posedge i_clock)
  begin
    if (i_reset)
      ack_q <= 1'b0;
    else
      ack_q <= req & ~ack_q;
  end

  // ***************************************************************
  // Bit set or clear command
  // ***************************************************************
  assign bit_idx = i_avs_writedata[`GPO_BITOP_IDX_HI:`GPO_BITOP_IDX_LO];
  assign bit_pos = i_avs_writedata[`GPO_BITOP_POS_HI:`GPO_BITOP_POS_LO];
  assign bit_val = i_avs_writedata[`GPO_BITOP_VAL];
  assign bit_go  = wr_go & hit(i_avs_address, `GPO_IDX_BIT_OP) & (i_avs_byteenable[1:0] == 2'b11);

  // ***************************************************************
  // Port registers
  // ***************************************************************
  gpo_port #(
    .IMPL (`GPO_PORT_A_IMPL)
  ) u_port_a (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_data_we     (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_A_DATA)),
    .i_dir_we      (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_A_DIR)),
    .i_pu_we       (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_A_PULLUP)),
    .i_wdata       (wbyte),
    .i_bit_data_we (bit_go & hit(bit_idx, `GPO_IDX_PORT_A_DATA)),
    .i_bit_dir_we  (bit_go & hit(bit_idx, `GPO_IDX_PORT_A_DIR)),
    .i_bit_pos     (bit_pos),
    .i_bit_val     (bit_val),
    .o_data        (a_data),
    .o_dir         (a_dir),
    .o_pu          (a_pu)
  );

  // Input-only bit is left out of the implemented mask of port B
  gpo_port #(
    .IMPL (`GPO_PORT_B_IMPL)
  ) u_port_b (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_data_we     (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_B_DATA)),
    .i_dir_we      (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_B_DIR)),
    .i_pu_we       (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_B_PULLUP)),
    .i_wdata       (wbyte),
    .i_bit_data_we (bit_go & hit(bit_idx, `GPO_IDX_PORT_B_DATA)),
    .i_bit_dir_we  (bit_go & hit(bit_idx, `GPO_IDX_PORT_B_DIR)),
    .i_bit_pos     (bit_pos),
    .i_bit_val     (bit_val),
    .o_data        (b_data),
    .o_dir         (b_dir),
    .o_pu          (b_pu)
  );

  gpo_port #(
    .IMPL (`GPO_PORT_C_IMPL)
  ) u_port_c (
    .i_clock       (i_clock),
    .i_reset       (i_reset),
    .i_data_we     (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_C_DATA)),
    .i_dir_we      (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_C_DIR)),
    .i_pu_we       (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_PORT_C_PULLUP)),
    .i_wdata       (wbyte),
    .i_bit_data_we (bit_go & hit(bit_idx, `GPO_IDX_PORT_C_DATA)),
    .i_bit_dir_we  (bit_go & hit(bit_idx, `GPO_IDX_PORT_C_DIR)),
    .i_bit_pos     (bit_pos),
    .i_bit_val     (bit_val),
    .o_data        (c_data),
    .o_dir         (c_dir),
    .o_pu          (c_pu)
  );

  // ***************************************************************
  // Open-drain control, write-only
  // ***************************************************************
  always @(posedge i_clock)
  begin
    if (i_reset)
      od_q <= 1'b0;
    else if (wr_go & lane0 & hit(i_avs_address, `GPO_IDX_OD_CTRL))
      od_q <= wbyte[`GPO_OD_SELECT_BIT];
  end

  // ***************************************************************
  // Pin drivers
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < `GPO_PORT_A_W; g = g + 1)
    begin : g_pa
      gpo_pin_drv #(
        .OD_CAPABLE (0)
      ) u_drv (
        .i_latch (a_data[g]),
        .i_dir   (a_dir[g]),
        .i_od_en (1'b0),
        .o_out   (o_port_a_out[g]),
        .o_oe    (o_port_a_oe[g])
      );
    end
    for (g = 0; g < `GPO_PORT_B_W; g = g + 1)
    begin : g_pb
      gpo_pin_drv #(
        .OD_CAPABLE ((g == `GPO_OD_PIN_BIT) ? 1 : 0)
      ) u_drv (
        .i_latch (b_data[g]),
        .i_dir   (b_dir[g]),
        .i_od_en (od_q),
        .o_out   (o_port_b_out[g]),
        .o_oe    (o_port_b_oe[g])
      );
    end
    for (g = 0; g < `GPO_PORT_C_W; g = g + 1)
    begin : g_pc
      gpo_pin_drv #(
        .OD_CAPABLE (0)
      ) u_drv (
        .i_latch (c_data[g]),
        .i_dir   (c_dir[g]),
        .i_od_en (1'b0),
        .o_out   (o_port_c_out[g]),
        .o_oe    (o_port_c_oe[g])
      );
    end
  endgenerate

  // Input-only pin never gets a pull-up (mask keeps b_pu bit 5 zero)
  assign o_port_a_pullup = a_pu[`GPO_PORT_A_W-1:0];
  assign o_port_b_pullup = b_pu[`GPO_PORT_B_W-1:0];
  assign o_port_c_pullup = c_pu[`GPO_PORT_C_W-1:0];

  // ***************************************************************
  // Read path
  // ***************************************************************
  assign a_level    = {{(8-`GPO_PORT_A_W){1'b0}}, i_port_a_pin};
  assign b_level    = {{(8-`GPO_PORT_B_W){1'b0}}, i_port_b_pin}
                      | (i_ext_reset_option ? `GPO_INPUT_ONLY_MASK : `GPO_RST_REG);
  assign c_level    = i_port_c_pin;
  assign b_dir_view = b_dir | `GPO_INPUT_ONLY_MASK;

  always @*
  begin
    rdata_d = `GPO_RST_BUS;
    case (i_avs_address)
      `GPO_IDX_PORT_A_DATA:   rdata_d[7:0] = a_level;
      `GPO_IDX_PORT_B_DATA:   rdata_d[7:0] = b_level;
      `GPO_IDX_PORT_C_DATA:   rdata_d[7:0] = c_level;
      `GPO_IDX_PORT_A_DIR:    rdata_d[7:0] = a_dir;
      `GPO_IDX_PORT_B_DIR:    rdata_d[7:0] = b_dir_view;
      `GPO_IDX_PORT_C_DIR:    rdata_d[7:0] = c_dir;
      // Pull-up enables are write-only except the fixed input-only bit
      `GPO_IDX_PORT_B_PULLUP: rdata_d[7:0] = `GPO_INPUT_ONLY_MASK;
      default:                rdata_d = `GPO_RST_BUS;
    endcase
  end

  always @(posedge i_clock)
  begin
    if (i_reset)
      rdata_q <= `GPO_RST_BUS;
    else if (i_avs_read & ~ack_q)
      rdata_q <= rdata_d;
  end

endmodule

`default_nettype wire

//--- test/gpo_top_asserts.sv
// Purpose: Bus and pin assertions of the GPIO block
// Assumes: One clock, synchronous active-high reset
// Notes:   Helper flops shadow port B bit 0 latch, direction and open-drain
`timescale 1ns/1ps
`default_nettype none
`include "gpo_defs.vh"
module gpo_top_asserts (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest,
  input  wire logic        i_ext_reset_option,
  input  wire logic [7:0]  i_port_c_pin,
  input  wire logic [5:0]  o_port_b_out,
  input  wire logic [5:0]  o_port_b_oe,
  input  wire logic [5:0]  o_port_b_pullup,
  input  wire logic [7:0]  o_port_c_out,
  input  wire logic [7:0]  o_port_c_pullup
);
  logic od_q;
  logic dir_q;
  logic lat_q;
  wire  acc  = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire  bop  = acc && i_avs_address == `GPO_IDX_BIT_OP && i_avs_byteenable[1];
  wire  bop0 = bop && i_avs_writedata[10:8] == 3'h0;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // ******************************
  // Shadow state of port B bit 0
  // ******************************
  always @(posedge i_clock)
  begin
    if (i_reset)
    begin
      od_q  <= 1'b0;
      dir_q <= 1'b0;
      lat_q <= 1'b0;
    end
    else
    begin
      if (acc && i_avs_address == `GPO_IDX_OD_CTRL) od_q <= i_avs_writedata[0];
      if (acc && i_avs_address == `GPO_IDX_PORT_B_DIR) dir_q <= i_avs_writedata[0];
      if (acc && i_avs_address == `GPO_IDX_PORT_B_DATA) lat_q <= i_avs_writedata[0];
      if (bop0 && i_avs_writedata[7:0] == `GPO_IDX_PORT_B_DIR) dir_q <= i_avs_writedata[11];
      if (bop0 && i_avs_writedata[7:0] == `GPO_IDX_PORT_B_DATA) lat_q <= i_avs_writedata[11];
    end
  end
  sequence s_wr(idx);
    acc && i_avs_address == idx;
  endsequence
  sequence s_rd(idx);
    i_avs_read && !o_avs_waitrequest && i_avs_address == idx;
  endsequence
  // ******************************
  // Assertions
  // ******************************
  a_one_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_pu_c_load: assert property (s_wr(`GPO_IDX_PORT_C_PULLUP) |=> o_port_c_pullup == $past(i_avs_writedata[7:0]))
    else $error("port C pull-up enables differ from written byte");
  a_b5_no_pu: assert property (!o_port_b_pullup[5])
    else $error("input-only pin shows a pull-up");
  a_pu_b_rdbk: assert property (s_rd(`GPO_IDX_PORT_B_PULLUP) |-> o_avs_readdata == 32'h0000_0020)
    else $error("port B pull-up readback wrong");
  a_od_no_high: assert property (od_q && o_port_b_oe[0] |-> !o_port_b_out[0])
    else $error("open-drain pin driven high");
  a_od_float: assert property (od_q && dir_q |-> o_port_b_oe[0] == !lat_q)
    else $error("open-drain enable does not follow inverted latch");
  a_pp_restore: assert property (!od_q |-> o_port_b_oe[0] == dir_q && o_port_b_out[0] == lat_q)
    else $error("push-pull pin does not follow direction and latch");
  a_b5_ext: assert property (s_rd(`GPO_IDX_PORT_B_DATA) ##0 i_ext_reset_option |-> o_avs_readdata[5])
    else $error("input-only data bit not forced with reset option");
  a_rd_pins: assert property (s_rd(`GPO_IDX_PORT_C_DATA) |-> o_avs_readdata == {24'h00_0000, $past(i_port_c_pin)})
    else $error("port C read differs from pin levels");
  a_c_byte: assert property (s_wr(`GPO_IDX_PORT_C_DATA) |=> o_port_c_out == $past(i_avs_writedata[7:0]))
    else $error("port C latch differs from written byte");
  a_c_bitop: assert property (bop && i_avs_writedata[7:0] == `GPO_IDX_PORT_C_DATA |=>
    o_port_c_out == (($past(o_port_c_out) & ~(8'h01 << $past(i_avs_writedata[10:8])))
    | ({7'h00, $past(i_avs_writedata[11])} << $past(i_avs_writedata[10:8]))))
    else $error("bit operation disturbed other port C bits");
  a_dir_reset: assert property ($past(i_reset) |-> o_port_b_oe == 6'h00)
    else $error("output enabled right after reset");
endmodule
bind gpo_top gpo_top_asserts gpo_top_asserts_i (.i_clock(i_clock), .i_reset(i_reset),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_ext_reset_option(i_ext_reset_option), .i_port_c_pin(i_port_c_pin),
  .o_port_b_out(o_port_b_out), .o_port_b_oe(o_port_b_oe), .o_port_b_pullup(o_port_b_pullup),
  .o_port_c_out(o_port_c_out), .o_port_c_pullup(o_port_c_pullup));
`default_nettype wire

//--- test/gpo_tb_board.sv
// Purpose: Board circuitry on one port's pins
// Assumes: External drivers only on pins the block leaves undriven
// Notes:   A floating pin toggles each cycle so no stale level survives
`timescale 1ns/1ps
`default_nettype none
module gpo_tb_board #(
  parameter int         W  = 8,
  parameter logic [7:0] PU = 8'h00
) (
  input  wire logic         i_clock,
  input  wire logic [W-1:0] i_out,
  input  wire logic [W-1:0] i_oe,
  input  wire logic [W-1:0] i_pullup,
  input  wire logic [W-1:0] i_ext_en,
  input  wire logic [W-1:0] i_ext_val,
  output var  logic [W-1:0] o_pin
);
  logic [W-1:0] float_q = '0;
  always @(posedge i_clock)
    float_q <= ~float_q;
  // Undriven open-drain high comes from the board resistor or the block's pull-up enable
  always_comb
    for (int b = 0; b < W; b++)
      o_pin[b] = i_oe[b] ? i_out[b] : i_ext_en[b] ? i_ext_val[b] : (i_pullup[b] || PU[b]) ? 1'b1 : float_q[b];
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Self-checking bench of the GPIO block against a port model
// Assumes: Avalon-MM master with one request at a time
// Notes:   Port B bit 0 has a board pull-up for open-drain use
`timescale 1ns/1ps
`default_nettype none
`include "gpo_defs.vh"
module tb_top;
  localparam logic [7:0] DAT [3] = '{`GPO_IDX_PORT_A_DATA, `GPO_IDX_PORT_B_DATA, `GPO_IDX_PORT_C_DATA};
  localparam logic [7:0] DIR [3] = '{`GPO_IDX_PORT_A_DIR, `GPO_IDX_PORT_B_DIR, `GPO_IDX_PORT_C_DIR};
  localparam logic [7:0] PUR [3] = '{`GPO_IDX_PORT_A_PULLUP, `GPO_IDX_PORT_B_PULLUP, `GPO_IDX_PORT_C_PULLUP};
  localparam logic [7:0] IMP [3] = '{8'h01, 8'h1f, 8'hff};
  localparam logic [7:0] RDM [3] = '{8'h01, 8'h3f, 8'hff};
  logic        i_clock = 1'b0;
  logic        i_reset = 1'b1;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic        ext_opt = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [3:0]  ben     = 4'h0;
  logic [23:0] ext_en  = 24'hff_ffff;
  logic [23:0] ext_v   = 24'h00_0000;
  logic [7:0]  m_lat [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]  m_dir [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0]  m_pu  [3] = '{8'h00, 8'h00, 8'h00};
  logic        m_od    = 1'b0;
  int          n_errors    = 0;
  int          checks_done = 0;
  wire  [31:0] rdata;
  wire         waitreq;
  wire  [23:0] out_w;
  wire  [23:0] oe_w;
  wire  [23:0] pu_w;
  wire  [23:0] pin_w;
  // Gaps between the port slices carry no pin
  assign {out_w[15:14], out_w[7:1]} = 9'h000;
  assign {oe_w[15:14], oe_w[7:1]}   = 9'h000;
  assign {pu_w[15:14], pu_w[7:1]}   = 9'h000;
  assign {pin_w[15:14], pin_w[7:1]} = 9'h000;
  always #2.5 i_clock = ~i_clock;
  gpo_top gpo_top_i (.i_clock(i_clock), .i_reset(i_reset), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(ben), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_ext_reset_option(ext_opt), .i_port_a_pin(pin_w[0]), .o_port_a_out(out_w[0]),
    .o_port_a_oe(oe_w[0]), .o_port_a_pullup(pu_w[0]), .i_port_b_pin(pin_w[13:8]), .o_port_b_out(out_w[13:8]),
    .o_port_b_oe(oe_w[13:8]), .o_port_b_pullup(pu_w[13:8]), .i_port_c_pin(pin_w[23:16]),
    .o_port_c_out(out_w[23:16]), .o_port_c_oe(oe_w[23:16]), .o_port_c_pullup(pu_w[23:16]));
  gpo_tb_board #(.W(1)) gpo_tb_board_a_i (.i_clock(i_clock), .i_out(out_w[0]), .i_oe(oe_w[0]),
    .i_pullup(pu_w[0]), .i_ext_en(ext_en[0]), .i_ext_val(ext_v[0]), .o_pin(pin_w[0]));
  gpo_tb_board #(.W(6), .PU(8'h01)) gpo_tb_board_b_i (.i_clock(i_clock), .i_out(out_w[13:8]), .i_oe(oe_w[13:8]),
    .i_pullup(pu_w[13:8]), .i_ext_en(ext_en[13:8]), .i_ext_val(ext_v[13:8]), .o_pin(pin_w[13:8]));
  gpo_tb_board #(.W(8)) gpo_tb_board_c_i (.i_clock(i_clock), .i_out(out_w[23:16]), .i_oe(oe_w[23:16]),
    .i_pullup(pu_w[23:16]), .i_ext_en(ext_en[23:16]), .i_ext_val(ext_v[23:16]), .o_pin(pin_w[23:16]));
  // ******************************
  // Checking and bus tasks
  // ******************************
  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Waitrequest sampled at the rising edge, ahead of that edge's register updates
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clock);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    ben <= be;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (waitreq !== 1'b0 && n < 64);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) n_errors++;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
    for (int p = 0; p < 3; p++)
    begin
      if (a == DAT[p]) m_lat[p] = d[7:0];
      if (a == DIR[p]) m_dir[p] = d[7:0];
      if (a == PUR[p]) m_pu[p] = d[7:0];
      if (a == `GPO_IDX_BIT_OP && d[7:0] == DAT[p]) m_lat[p][d[10:8]] = d[11];
      if (a == `GPO_IDX_BIT_OP && d[7:0] == DIR[p]) m_dir[p][d[10:8]] = d[11];
    end
    if (a == `GPO_IDX_OD_CTRL) m_od = d[0];
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    chk(nm, q, {24'h00_0000, e});
  endtask
  // ******************************
  // Port model
  // ******************************
  function automatic logic [7:0] e_oe(int p);
    e_oe = m_dir[p] & IMP[p];
    if (p == 1 && m_od && m_dir[1][0]) e_oe[0] = !m_lat[1][0];
  endfunction
  function automatic logic [7:0] e_val(int p);
    e_val = m_lat[p];
    if (p == 1 && m_od) e_val[0] = 1'b0;
  endfunction
  function automatic logic [7:0] e_pin(int p);
    logic [7:0] eo;
    logic [7:0] en;
    eo = e_oe(p);
    en = ext_en[8*p +: 8];
    e_pin = ((eo & e_val(p)) | (~eo & en & ext_v[8*p +: 8]) | (~eo & ~en & 8'h01)) & RDM[p];
    if (p == 1 && ext_opt) e_pin[5] = 1'b1;
  endfunction
  task automatic pins();
    @(negedge i_clock);
    for (int p = 0; p < 3; p++)
    begin
      chk("oe", {24'h00_0000, oe_w[8*p +: 8] & RDM[p]}, {24'h00_0000, e_oe(p)});
      chk("out", {24'h00_0000, out_w[8*p +: 8] & e_oe(p)}, {24'h00_0000, e_val(p) & e_oe(p)});
      chk("pullup", {24'h00_0000, pu_w[8*p +: 8] & RDM[p]}, {24'h00_0000, m_pu[p] & IMP[p]});
      rchk("data", DAT[p], e_pin(p));
      rchk("dir", DIR[p], (m_dir[p] & IMP[p]) | (p == 1 ? `GPO_INPUT_ONLY_MASK : 8'h00));
    end
  endtask
  // ******************************
  // Scenarios
  // ******************************
  initial
  begin
    logic [31:0] q;
    void'($urandom(76251));
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    pins();
    rchk("od_ctrl", `GPO_IDX_OD_CTRL, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    for (int p = 0; p < 3; p++)
    begin
      wreg(PUR[p], 32'h0000_00ff);
      rchk("pullup_rd", PUR[p], p == 1 ? 8'h20 : 8'h00);
    end
    bus(1'b1, DAT[2], 32'h0000_00ff, 4'h0, q);
    wreg(8'h10, 32'h0000_00ff);
    pins();
    wreg(`GPO_IDX_BIT_OP, {20'h0_0000, 1'b1, 3'h0, DAT[1]});
    wreg(`GPO_IDX_BIT_OP, {20'h0_0000, 1'b1, 3'h0, DIR[1]});
    wreg(`GPO_IDX_OD_CTRL, 32'h0000_0001);
    ext_en[8] <= 1'b0;
    pins();
    wreg(`GPO_IDX_BIT_OP, {20'h0_0000, 1'b0, 3'h0, DAT[1]});
    pins();
    wreg(`GPO_IDX_OD_CTRL, 32'h0000_0000);
    pins();
    ext_en[8] <= 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      int p;
      int k;
      p = $urandom % 3;
      k = $urandom % 5;
      ext_v <= 24'($urandom);
      ext_opt <= 1'($urandom);
      case (k)
        0: wreg(DAT[p], {24'h00_0000, 8'($urandom)});
        1: wreg(DIR[p], {24'h00_0000, 8'($urandom)});
        2: wreg(PUR[p], {24'h00_0000, 8'($urandom)});
        3: wreg(`GPO_IDX_BIT_OP, {20'h0_0000, 1'($urandom), 3'($urandom), ($urandom % 2) ? DAT[p] : DIR[p]});
        default: wreg(`GPO_IDX_OD_CTRL, {24'h00_0000, 8'($urandom)});
      endcase
      pins();
    end
    complete_run();
  end
  initial
  begin
    repeat (40000) @(posedge i_clock);
    n_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
